// file: common/mac_cfg.svh
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
`define MAC_OFF_CTRL 12'h000
`define MAC_OFF_STAT 12'h004
`define MAC_OFF_RESV 12'h008
`define MAC_OFF_LINE 12'h00c
`define MAC_CTRL_CACHE_EN 0
`define MAC_CTRL_WT_EXC 1
`define MAC_CTRL_ZERO_EXC 2
`define MAC_CTRL_RST 3'h1
`define MAC_LINES 4
`define MAC_PAGE_SHIFT 12
`endif

// file: common/mac_pkg.sv
package mac_pkg;
    typedef enum logic [3:0] {
        OP_LOAD, OP_STORE, OP_LDRES, OP_STCOND, OP_BLK_STORE,
        OP_BLK_FLUSH, OP_BLK_ZERO, OP_ICINV, OP_SYNC
    } mac_op_type;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} mac_size_type;
    typedef enum logic [1:0] {ST_IDLE, ST_CLAIM, ST_MEM, ST_FIN} mac_state_type;
    typedef enum logic [1:0] {MC_READ, MC_WRITE, MC_CLAIM} mac_mcmd_type;
endpackage

// file: rtl/mac_policy.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "mac_cfg.svh"
module mac_policy #(
    parameter int LINES = `MAC_LINES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire mac_pkg::mac_op_type req_op,
    input wire mac_pkg::mac_size_type req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic req_spec,
    input wire logic req_attr_w,
    input wire logic req_attr_i,
    input wire logic req_attr_m,
    input wire logic req_attr_g,
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    output logic rsp_ok,
    output logic rsp_exc_align,
    output logic rsp_exc_dsi,
    output logic mem_req,
    output mac_pkg::mac_mcmd_type mem_cmd,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic snoop_valid,
    input wire logic [31:0] snoop_addr,
    output logic resv_valid,
    output logic [31:0] resv_addr
);
    localparam int IW = $clog2(LINES);
    localparam int TW = 30 - IW;

    typedef struct packed {
        mac_pkg::mac_state_type st;
        mac_pkg::mac_op_type op;
        mac_pkg::mac_size_type sz;
        logic [31:0] addr;
        logic [31:0] wd;
        logic [3:0] be;
        logic wt;
        logic hit;
        logic fill;
        logic cw;
        logic exa;
        logic exd;
        logic ok;
        logic mneed;
        logic [31:0] rdat;
        logic resv_v;
        logic [29:0] resv_a;
        logic [LINES-1:0] v;
        logic [LINES-1:0] d;
        logic [LINES-1:0][TW-1:0] tag;
        logic [LINES-1:0][31:0] data;
        logic [2:0] ctrl;
        mac_pkg::mac_mcmd_type mcmd;
        logic [31:0] maddr;
        logic [31:0] mwd;
        logic [3:0] mbe;
        logic rsp;
        logic [31:0] rdata;
        logic rok;
        logic rea;
        logic red;
        logic ap_done;
        logic [31:0] prd;
        logic perr;
    } mac_regs_type;

    mac_regs_type s_reg;
    mac_regs_type s_next;

    logic acc;
    logic use_c;
    logic wt_eff;
    logic res_op;
    logic acc_op;
    logic misal;
    logic req_hit;
    logic cond_ok;
    logic [IW-1:0] req_idx;
    logic [IW-1:0] fin_idx;
    logic [3:0] be_w;
    logic [31:0] wlane;
    logic [31:0] merged;
    logic [31:0] fin_word;
    logic [31:0] size_mask;
    logic [31:0] rd_mux;
    logic [31:0] line_bits;
    logic map_hit;
    logic apb_acc;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    // guarded hold: speculative guarded accesses wait.
    assign req_ready = (s_reg.st == mac_pkg::ST_IDLE) & ~(req_spec & req_attr_g);
    assign acc = req_valid & req_ready;
    assign req_idx = req_addr[IW+1:2];
    assign fin_idx = s_reg.addr[IW+1:2];
    // page attributes: four bits arrive with each request.
    assign wt_eff = req_attr_w & ~req_attr_i;
    // cache use when allowed and enabled.
    assign use_c = s_reg.ctrl[`MAC_CTRL_CACHE_EN] & ~req_attr_i;
    // per-page attributes: no attribute is cached, each access uses its own.
    assign req_hit = use_c & s_reg.v[req_idx] & (s_reg.tag[req_idx] == req_addr[31:IW+2]);
    assign res_op = (req_op == mac_pkg::OP_LDRES) | (req_op == mac_pkg::OP_STCOND);
    assign acc_op = res_op | (req_op == mac_pkg::OP_LOAD) | (req_op == mac_pkg::OP_STORE);
    // split or refuse: misaligned and double-word accesses trap.
    assign misal = acc_op & ((req_size == mac_pkg::SZ_HALF & req_addr[0])
        | (req_size == mac_pkg::SZ_WORD & |req_addr[1:0])
        | (req_size == mac_pkg::SZ_DWORD)
        | (res_op & req_size != mac_pkg::SZ_WORD));
    // reservation match: same word, same processor.
    assign cond_ok = s_reg.resv_v & (s_reg.resv_a == req_addr[31:2]);
    assign wlane = req_wdata << {req_addr[1:0], 3'h0};

    // byte lanes: one enable mask per aligned access.
    always_comb begin
        if (req_size == mac_pkg::SZ_BYTE) begin
            be_w = 4'h1 << req_addr[1:0];
        end else if (req_size == mac_pkg::SZ_HALF) begin
            be_w = 4'h3 << req_addr[1:0];
        end else begin
            be_w = 4'hf;
        end
    end

    always_comb begin
        if (s_reg.sz == mac_pkg::SZ_BYTE) begin
            size_mask = 32'h0000_00ff;
        end else if (s_reg.sz == mac_pkg::SZ_HALF) begin
            size_mask = 32'h0000_ffff;
        end else begin
            size_mask = 32'hffff_ffff;
        end
    end

    assign fin_word = s_reg.hit ? s_reg.data[fin_idx] : s_reg.rdat;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign merged[8*b+:8] = s_reg.be[b] ? s_reg.wd[8*b+:8] : s_reg.data[fin_idx][8*b+:8];
    end

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    assign apb_acc = psel & penable;
    assign map_hit = (paddr == `MAC_OFF_CTRL) | (paddr == `MAC_OFF_STAT)
        | (paddr == `MAC_OFF_RESV) | (paddr == `MAC_OFF_LINE);

    always_comb begin
        line_bits = 32'h0;
        line_bits[LINES-1:0] = s_reg.v;
        line_bits[8+:LINES] = s_reg.d;
        unique case (paddr)
            `MAC_OFF_CTRL: rd_mux = {29'h0, s_reg.ctrl};
            `MAC_OFF_STAT: rd_mux = {30'h0, s_reg.st != mac_pkg::ST_IDLE, s_reg.resv_v};
            `MAC_OFF_RESV: rd_mux = {s_reg.resv_a, 2'h0};
            `MAC_OFF_LINE: rd_mux = line_bits;
            default: rd_mux = 32'h0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic claim;
        logic stok;
        logic rexc;
        claim = 1'b0;
        stok = 1'b0;
        rexc = res_op & wt_eff & s_reg.ctrl[`MAC_CTRL_WT_EXC];
        s_next = s_reg;
        s_next.rsp = 1'b0;

        if (apb_acc & ~s_reg.ap_done) begin
            s_next.ap_done = 1'b1;
            s_next.prd = rd_mux;
            s_next.perr = ~map_hit;
        end
        if (apb_acc & s_reg.ap_done) begin
            s_next.ap_done = 1'b0;
            if (pwrite & ~s_reg.perr & paddr == `MAC_OFF_CTRL) begin
                s_next.ctrl = pwdata[2:0];
            end
        end

        // remote update: another master's store kills the reservation.
        if (snoop_valid & (snoop_addr[31:2] == s_reg.resv_a)) begin
            s_next.resv_v = 1'b0;
        end

        unique case (s_reg.st)
            mac_pkg::ST_IDLE: begin
                if (acc) begin
                    s_next.op = req_op;
                    s_next.sz = req_size;
                    s_next.addr = req_addr;
                    s_next.wd = wlane;
                    s_next.be = be_w;
                    s_next.wt = wt_eff;
                    s_next.hit = req_hit;
                    s_next.fill = 1'b0;
                    s_next.cw = 1'b0;
                    s_next.exa = misal;
                    s_next.exd = 1'b0;
                    s_next.ok = 1'b1;
                    s_next.mneed = 1'b0;
                    s_next.mcmd = mac_pkg::MC_WRITE;
                    s_next.maddr = {req_addr[31:2], 2'h0};
                    s_next.mwd = wlane;
                    s_next.mbe = be_w;
                    unique case (req_op)
                        mac_pkg::OP_LOAD, mac_pkg::OP_LDRES: begin
                            // write-through pair: trap when so configured.
                            s_next.exd = rexc;
                            // cached load: memory read only on a miss.
                            s_next.mneed = ~req_hit;
                            s_next.mcmd = mac_pkg::MC_READ;
                            // dirty line kept: a fill never drops it.
                            s_next.fill = use_c & ~req_hit
                                & ~(s_reg.v[req_idx] & s_reg.d[req_idx]);
                        end
                        mac_pkg::OP_STORE, mac_pkg::OP_STCOND: begin
                            stok = (req_op == mac_pkg::OP_STORE) | cond_ok;
                            s_next.ok = stok;
                            s_next.exd = rexc;
                            s_next.cw = stok & req_hit;
                            // write-through store: memory written as well.
                            s_next.mneed = stok & (~req_hit | wt_eff);
                            // ownership first: coherent cached stores claim.
                            claim = stok & use_c & req_attr_m;
                        end
                        mac_pkg::OP_BLK_STORE, mac_pkg::OP_BLK_FLUSH: begin
                            // coherent copy: written even when clean.
                            // local copy: written only when dirty.
                            s_next.mneed = req_hit & (s_reg.d[req_idx] | req_attr_m);
                            s_next.mwd = s_reg.data[req_idx];
                            s_next.mbe = 4'hf;
                        end
                        mac_pkg::OP_BLK_ZERO: begin
                            // dirty line kept: the zero word goes to memory instead.
                            s_next.fill = use_c & ~wt_eff
                                & (req_hit | ~(s_reg.v[req_idx] & s_reg.d[req_idx]));
                            // cached copy zeroed: a write-through hit stays current.
                            s_next.cw = wt_eff & req_hit;
                            s_next.wd = 32'h0;
                            s_next.be = 4'hf;
                            s_next.mwd = 32'h0;
                            s_next.mbe = 4'hf;
                            // zeroing trap: optional for uncached and write-through targets.
                            if (~(use_c & ~wt_eff)) begin
                                s_next.exa = s_reg.ctrl[`MAC_CTRL_ZERO_EXC];
                                s_next.mneed = 1'b1;
                            end else if (~s_next.fill) begin
                                s_next.mneed = 1'b1;
                            end
                        end
                        // no stall: instruction invalidate is a no-op.
                        // barrier: all earlier accesses are already done.
                        default: begin
                        end
                    endcase
                    if (s_next.exa | s_next.exd) begin
                        s_next.mneed = 1'b0;
                        s_next.cw = 1'b0;
                        s_next.fill = 1'b0;
                        claim = 1'b0;
                    end
                    if (claim) begin
                        s_next.st = mac_pkg::ST_CLAIM;
                    end else if (s_next.mneed) begin
                        s_next.st = mac_pkg::ST_MEM;
                    end else begin
                        s_next.st = mac_pkg::ST_FIN;
                    end
                end
            end
            mac_pkg::ST_CLAIM: begin
                if (mem_ack) begin
                    s_next.st = s_reg.mneed ? mac_pkg::ST_MEM : mac_pkg::ST_FIN;
                end
            end
            mac_pkg::ST_MEM: begin
                if (mem_ack) begin
                    s_next.rdat = mem_rdata;
                    s_next.st = mac_pkg::ST_FIN;
                end
            end
            mac_pkg::ST_FIN: begin
                s_next.st = mac_pkg::ST_IDLE;
                s_next.rsp = 1'b1;
                s_next.rea = s_reg.exa;
                s_next.red = s_reg.exd;
                s_next.rok = s_reg.ok & ~s_reg.exa & ~s_reg.exd;
                s_next.rdata = (fin_word >> {s_reg.addr[1:0], 3'h0}) & size_mask;
                // reservation cleared by every conditional store.
                if (s_reg.op == mac_pkg::OP_STCOND) begin
                    s_next.resv_v = 1'b0;
                end
                if (~s_reg.exa & ~s_reg.exd) begin
                    if (s_reg.fill) begin
                        s_next.v[fin_idx] = 1'b1;
                        s_next.tag[fin_idx] = s_reg.addr[31:IW+2];
                        s_next.d[fin_idx] = (s_reg.op == mac_pkg::OP_BLK_ZERO);
                        s_next.data[fin_idx] = (s_reg.op == mac_pkg::OP_BLK_ZERO) ?
                            32'h0 : s_reg.rdat;
                    end
                    if (s_reg.cw) begin
                        s_next.data[fin_idx] = merged;
                        s_next.d[fin_idx] = s_reg.d[fin_idx] | ~s_reg.wt;
                    end
                    // reservation set and published; set beats a snoop.
                    // inhibited or cached: the reservation is kept alike.
                    if (s_reg.op == mac_pkg::OP_LDRES) begin
                        s_next.resv_v = 1'b1;
                        s_next.resv_a = s_reg.addr[31:2];
                    end
                    if (s_reg.hit & s_reg.op == mac_pkg::OP_BLK_STORE) begin
                        s_next.d[fin_idx] = 1'b0;
                    end
                    if (s_reg.hit & s_reg.op == mac_pkg::OP_BLK_FLUSH) begin
                        s_next.v[fin_idx] = 1'b0;
                        s_next.d[fin_idx] = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.ctrl <= `MAC_CTRL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s_reg.prd;
    assign pready = apb_acc & s_reg.ap_done;
    assign pslverr = pready & s_reg.perr;
    assign rsp_valid = s_reg.rsp;
    assign rsp_data = s_reg.rdata;
    assign rsp_ok = s_reg.rok;
    assign rsp_exc_align = s_reg.rea;
    assign rsp_exc_dsi = s_reg.red;
    assign mem_req = (s_reg.st == mac_pkg::ST_CLAIM) | (s_reg.st == mac_pkg::ST_MEM);
    assign mem_cmd = (s_reg.st == mac_pkg::ST_CLAIM) ? mac_pkg::MC_CLAIM : s_reg.mcmd;
    assign mem_addr = s_reg.maddr;
    assign mem_wdata = s_reg.mwd;
    assign mem_be = s_reg.mbe;
    assign resv_valid = s_reg.resv_v;
    assign resv_addr = {s_reg.resv_a, 2'h0};

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_atomic_beat: assert property (
        mem_req & mem_cmd == mac_pkg::MC_WRITE & ~mem_ack |=> $stable(mem_be) & $stable(mem_addr))
        else $error("write beat changed before its acknowledge");
    a_misalign_trap: assert property (
        acc & misal |=> ~mem_req ##1 rsp_valid & rsp_exc_align)
        else $error("misaligned access did not trap");
    a_resv_set: assert property (
        rsp_valid & $past(s_reg.op) == mac_pkg::OP_LDRES & ~rsp_exc_align & ~rsp_exc_dsi
        |-> resv_valid)
        else $error("reserving load left no reservation");
    a_cond_fail: assert property (
        acc & req_op == mac_pkg::OP_STCOND & ~misal & ~cond_ok
        |=> ~mem_req ##1 rsp_valid & ~rsp_ok)
        else $error("conditional store without reservation wrote");
    a_wt_dsi: assert property (
        acc & res_op & ~misal & wt_eff & s_reg.ctrl[`MAC_CTRL_WT_EXC]
        |=> ##1 rsp_valid & rsp_exc_dsi)
        else $error("write-through reservation did not trap");
    a_icinv_noop: assert property (
        acc & req_op == mac_pkg::OP_ICINV |=> ~mem_req ##1 rsp_valid & ~rsp_exc_align)
        else $error("instruction invalidate stalled or trapped");
    a_wt_write: assert property (
        acc & req_op == mac_pkg::OP_STORE & ~misal & wt_eff & ~req_attr_m
        |=> mem_req & mem_cmd == mac_pkg::MC_WRITE)
        else $error("write-through store skipped memory");
    a_wb_hit: assert property (
        acc & req_op == mac_pkg::OP_STORE & ~misal & req_hit & ~req_attr_w & ~req_attr_m
        |=> ~mem_req ##1 rsp_valid)
        else $error("write-back hit touched memory");
    a_ci_bypass: assert property (
        acc & req_op == mac_pkg::OP_LOAD & ~misal & req_attr_i
        |=> mem_req & mem_cmd == mac_pkg::MC_READ)
        else $error("inhibited load did not read memory");
    a_coh_claim: assert property (
        acc & req_op == mac_pkg::OP_STORE & ~misal & use_c & req_attr_m
        |=> mem_req & mem_cmd == mac_pkg::MC_CLAIM)
        else $error("coherent store did not claim ownership");
    a_clean_keep: assert property (
        acc & req_op == mac_pkg::OP_BLK_STORE & req_hit & ~s_reg.d[req_idx] & ~req_attr_m
        |=> ~mem_req)
        else $error("clean non-coherent block was written");
    a_guard_hold: assert property (
        req_spec & req_attr_g |-> ~req_ready)
        else $error("speculative guarded access accepted");
    a_cond_clear: assert property (
        rsp_valid & $past(s_reg.op) == mac_pkg::OP_STCOND |-> ~resv_valid)
        else $error("conditional store left reservation");

    c_pair_ok: cover property (rsp_valid & rsp_ok & $past(s_reg.op) == mac_pkg::OP_STCOND);
    c_ci_resv: cover property (acc & req_op == mac_pkg::OP_LDRES & req_attr_i);
    c_claim_done: cover property (s_reg.st == mac_pkg::ST_CLAIM & mem_ack);
    c_flush_dirty: cover property (acc & req_op == mac_pkg::OP_BLK_FLUSH & s_next.mneed);
endmodule

// file: testbench/mac_mem_model.sv
`timescale 1ns/1ps
module mac_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_req,
    input wire mac_pkg::mac_mcmd_type mem_cmd,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [256] = '{default: 32'h0};
    int wait_n = 0;
    int writes = 0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_n <= 0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && wait_n >= (slow ? 3 : 0)) begin
            mem_ack <= 1'b1;
            wait_n <= 0;
            mem_rdata <= mem[mem_addr[9:2]];
            if (mem_cmd == mac_pkg::MC_WRITE) begin
                writes <= writes + 1;
                for (int b = 0; b < 4; b++) begin
                    if (mem_be[b]) begin
                        mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
                    end
                end
            end
        end else begin
            mem_ack <= 1'b0;
            wait_n <= mem_req ? wait_n + 1 : 0;
            // Released data lines toggle each cycle between the last word and its inverse.
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// file: testbench/memory_attribute_cache_policy_test.sv
`timescale 1ns/1ps
module memory_attribute_cache_policy_test;
    logic pclk, presetn, psel, penable, pwrite, req_valid, req_spec, slow, err;
    logic req_attr_w, req_attr_i, req_attr_m, req_attr_g, snoop_valid, mem_ack;
    logic pready, pslverr, req_ready, rsp_valid, rsp_ok, rsp_exc_align, rsp_exc_dsi;
    logic mem_req, resv_valid;
    logic [3:0] mem_be;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, req_addr, req_wdata, snoop_addr, rsp_data, mem_addr;
    logic [31:0] mem_wdata, mem_rdata, resv_addr, seed, d, rd;
    mac_pkg::mac_op_type req_op;
    mac_pkg::mac_size_type req_size;
    mac_pkg::mac_mcmd_type mem_cmd;
    mac_pkg::mac_op_type nops [3] = '{mac_pkg::OP_ICINV, mac_pkg::OP_SYNC, mac_pkg::OP_BLK_FLUSH};
    int bad_count = 0;
    int compares = 0;
    int cyc, wr0;
    logic [31:0] ctrl_m = 32'h1, resv_m = 32'hffff_ffff;
    mac_policy #(.LINES(4)) dut_u (.*);
    mac_mem_model mem_u (.*);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        if (w && a == 12'h000) begin
            ctrl_m = wd;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(mac_pkg::mac_op_type o, mac_pkg::mac_size_type s, logic [31:0] a,
            logic [31:0] wd, logic [3:0] at);
        logic exc;
        @(posedge pclk);
        req_valid <= 1'b1;
        req_op <= o;
        req_size <= s;
        req_addr <= a;
        req_wdata <= wd;
        {req_attr_w, req_attr_i, req_attr_m, req_attr_g} <= at;
        slow <= seed[1];
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (rsp_valid !== 1'b1);
        exc = |a[1:0] || s != mac_pkg::SZ_WORD || (at[3] && !at[2] && ctrl_m[1]);
        if (o == mac_pkg::OP_STCOND) begin
            chk("sc model", {31'h0, !exc && resv_m == a}, {31'h0, rsp_ok});
            resv_m = 32'hffff_ffff;
        end else if (o == mac_pkg::OP_LDRES && !exc) begin
            resv_m = a;
        end
        chk("resv model", resv_m, resv_valid ? resv_addr : 32'hffff_ffff);
    endtask
    initial begin
        #100us;
        bad_count++;
        print_verdict();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, req_valid, req_spec, slow, snoop_valid} = '0;
        {req_attr_w, req_attr_i, req_attr_m, req_attr_g} = '0;
        {paddr, pwdata, req_addr, req_wdata, snoop_addr} = '0;
        req_op = mac_pkg::OP_SYNC;
        req_size = mac_pkg::SZ_WORD;
        seed = 32'h13;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h3, rd);
        $display("test registers done");
        // No word is cached while it is used as caching-inhibited, so no purge is due.
        d = rnd();
        op(mac_pkg::OP_STORE, mac_pkg::SZ_BYTE, 32'h101, d, 4'b1100);
        chk("byte store", {16'h0, d[7:0], 8'h0}, mem_u.mem[8'h40]);
        op(mac_pkg::OP_LOAD, mac_pkg::SZ_HALF, 32'h100, 0, 4'b0100);
        chk("half load", {16'h0, d[7:0], 8'h0}, rsp_data);
        op(mac_pkg::OP_LOAD, mac_pkg::SZ_WORD, 32'h20, 0, 4'b0000);
        d = rnd();
        op(mac_pkg::OP_STORE, mac_pkg::SZ_WORD, 32'h20, d, 4'b0000);
        chk("wb stale", 32'h0, mem_u.mem[8]);
        op(mac_pkg::OP_LOAD, mac_pkg::SZ_WORD, 32'h20, 0, 4'b0000);
        chk("wb load", d, rsp_data);
        wr0 = mem_u.writes;
        op(mac_pkg::OP_BLK_STORE, mac_pkg::SZ_WORD, 32'h20, 0, 4'b0000);
        chk("blk copy", d, mem_u.mem[8]);
        op(mac_pkg::OP_BLK_STORE, mac_pkg::SZ_WORD, 32'h20, 0, 4'b0000);
        chk("blk once", wr0 + 1, mem_u.writes);
        op(mac_pkg::OP_LOAD, mac_pkg::SZ_WORD, 32'h24, 0, 4'b1000);
        d = rnd();
        op(mac_pkg::OP_STORE, mac_pkg::SZ_WORD, 32'h24, d, 4'b1000);
        chk("wt mem", d, mem_u.mem[9]);
        op(mac_pkg::OP_LOAD, mac_pkg::SZ_WORD, 32'h24, 0, 4'b1000);
        chk("wt load", d, rsp_data);
        wr0 = mem_u.writes;
        repeat (2) op(mac_pkg::OP_BLK_STORE, mac_pkg::SZ_WORD, 32'h24, 0, 4'b1010);
        chk("coh copies", wr0 + 2, mem_u.writes);
        op(mac_pkg::OP_BLK_FLUSH, mac_pkg::SZ_WORD, 32'h24, 0, 4'b1010);
        chk("flush copy", wr0 + 3, mem_u.writes);
        apb(1'b0, 12'h00c, 32'h0);
        chk("line reg", 32'h1, rd);
        d = rnd();
        op(mac_pkg::OP_STORE, mac_pkg::SZ_WORD, 32'h44, d, 4'b0010);
        chk("coh store", d, mem_u.mem[17]);
        $display("test attributes done");
        op(mac_pkg::OP_LDRES, mac_pkg::SZ_WORD, 32'h50, 0, 4'b0100);
        chk("resv set", 32'h1, {31'h0, resv_valid});
        apb(1'b0, 12'h008, 32'h0);
        chk("resv reg", 32'h50, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("stat reg", 32'h1, rd);
        d = rnd();
        op(mac_pkg::OP_STCOND, mac_pkg::SZ_WORD, 32'h50, d, 4'b0100);
        chk("sc ok", 32'h1, {31'h0, rsp_ok});
        chk("sc mem", d, mem_u.mem[20]);
        op(mac_pkg::OP_STCOND, mac_pkg::SZ_WORD, 32'h50, ~d, 4'b0100);
        chk("sc again", 32'h0, {31'h0, rsp_ok});
        op(mac_pkg::OP_LDRES, mac_pkg::SZ_WORD, 32'h50, 0, 4'b0000);
        op(mac_pkg::OP_STCOND, mac_pkg::SZ_WORD, 32'h54, d, 4'b0000);
        chk("sc other", 32'h0, {31'h0, rsp_ok});
        op(mac_pkg::OP_LDRES, mac_pkg::SZ_WORD, 32'h50, 0, 4'b0000);
        op(mac_pkg::OP_STCOND, mac_pkg::SZ_WORD, 32'h50, d, 4'b0000);
        chk("sc cached", 32'h1, {31'h0, rsp_ok});
        op(mac_pkg::OP_LDRES, mac_pkg::SZ_WORD, 32'h50, 0, 4'b0000);
        @(posedge pclk);
        snoop_valid <= 1'b1;
        snoop_addr <= 32'h50;
        resv_m = 32'hffff_ffff;
        @(posedge pclk);
        snoop_valid <= 1'b0;
        op(mac_pkg::OP_STCOND, mac_pkg::SZ_WORD, 32'h50, d, 4'b0000);
        chk("sc snooped", 32'h0, {31'h0, rsp_ok});
        op(mac_pkg::OP_LDRES, mac_pkg::SZ_WORD, 32'h52, 0, 4'b0000);
        chk("lr misalign", 32'h1, {31'h0, rsp_exc_align});
        op(mac_pkg::OP_LDRES, mac_pkg::SZ_WORD, 32'h58, 0, 4'b1000);
        chk("lr wt", 32'h1, {31'h0, rsp_exc_dsi});
        op(mac_pkg::OP_LOAD, mac_pkg::SZ_DWORD, 32'h60, 0, 4'b0000);
        chk("dword", 32'h1, {31'h0, rsp_exc_align});
        $display("test reservation done");
        @(posedge pclk);
        req_spec <= 1'b1;
        req_attr_g <= 1'b1;
        @(posedge pclk);
        chk("spec guarded", 32'h0, {31'h0, req_ready});
        req_spec <= 1'b0;
        apb(1'b1, 12'h000, 32'h4);
        foreach (nops[k]) begin
            op(nops[k], mac_pkg::SZ_WORD, 32'h64, 0, 4'b0000);
            chk("no stall", 32'h2, cyc);
        end
        op(mac_pkg::OP_BLK_ZERO, mac_pkg::SZ_WORD, 32'h64, 0, 4'b1000);
        chk("zero trap", 32'h1, {31'h0, rsp_exc_align});
        $display("test cache ops done");
        print_verdict();
    end
endmodule
